// >>> core/fids_pkg.sv
// package: shared constants and types for the file/branch execution block
package fids_pkg;

  // widths
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int FADDR_W = 7;
  localparam int PC_W = 15;
  localparam int BR_W = 11;
  localparam int LATCH_W = 7;

  // instruction field positions
  localparam int OPC_HI = 13;
  localparam int OPC_LO = 8;
  localparam int BR_OPC_LO = 11;
  localparam int DEST_BIT = 7;
  localparam int LATCH_HI = 6;
  localparam int LATCH_LO = 3;

  // opcode values (bits 13:8, branch uses bits 13:11)
  localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
  localparam logic [5:0] OPC_INC_SKIP = 6'h0f;
  localparam logic [5:0] OPC_INC = 6'h0a;
  localparam logic [5:0] OPC_OR_FILE = 6'h04;
  localparam logic [5:0] OPC_OR_LIT = 6'h38;
  localparam logic [2:0] OPC_BRANCH = 3'h5;

  // reset values and arithmetic constants
  localparam logic [DATA_W-1:0] W_RST = 8'h00;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [DATA_W-1:0] ONE = 8'h01;
  localparam logic [DATA_W-1:0] ZERO = 8'h00;
  localparam logic [DATA_W-1:0] ALL_ONES = 8'hff;

  // decoded operation
  typedef enum logic [2:0] {
    OP_NONE,
    OP_DEC_SKIP,
    OP_INC_SKIP,
    OP_INC,
    OP_OR_FILE,
    OP_OR_LIT,
    OP_BRANCH
  } fids_op_t;

  // execution mode: normal, or discarding the word after a skip or branch
  typedef enum logic {
    MODE_EXEC,
    MODE_FLUSH
  } fids_mode_t;

endpackage

// >>> core/fids_alu.sv
// arithmetic unit: increment, decrement and inclusive or on 8-bit operands
`timescale 1ns/1ps
module fids_alu #(
  parameter int DATA_W = fids_pkg::DATA_W
) (
  // operation and operands
  input wire fids_pkg::fids_op_t op,
  input wire logic [DATA_W-1:0] work,
  input wire logic [DATA_W-1:0] file,
  input wire logic [DATA_W-1:0] lit,
  // result
  output logic [DATA_W-1:0] result,
  output logic res_zero
);

  // one result path per operation; unknown operations pass the file value
  always_comb
  begin
    unique case (op)
      fids_pkg::OP_DEC_SKIP: result = DATA_W'(file - fids_pkg::ONE);
      fids_pkg::OP_INC_SKIP, fids_pkg::OP_INC: result = DATA_W'(file + fids_pkg::ONE);
      fids_pkg::OP_OR_FILE: result = work | file;
      fids_pkg::OP_OR_LIT: result = work | lit;
      default: result = file;
    endcase
  end

  // zero detect feeds both the skip decision and the zero flag
  assign res_zero = (result == fids_pkg::ZERO);

endmodule

// >>> core/fids_exec.sv
// execution unit for increment/decrement-skip, inclusive or and unconditional branch
//
// How it works
// - decrement-and-skip subtracts one from the addressed file and sends it to work or file by d, flags untouched.
// - a zero decrement result discards the next word as a nop, so the instruction takes two cycles.
// - increment-and-skip adds one to the addressed file and sends it to work or file by d, flags untouched.
// - a zero increment-and-skip result discards the next word as a nop, giving two cycles.
// - the branch loads its 11-bit immediate into program counter bits 10:0.
// - the branch fills program counter bits 14:11 from high-latch bits 6:3.
// - the branch always takes two cycles, the prefetched word being discarded.
// - or-with-literal ors work with the 8-bit literal into work and updates zero.
// - increment adds one to the addressed file, sends it by d and updates zero.
// - or-with-file ors work with the addressed file, sends it by d and updates zero.
`timescale 1ns/1ps
module fids_exec #(
  parameter int DATA_W = fids_pkg::DATA_W,
  parameter int FADDR_W = fids_pkg::FADDR_W,
  parameter int PC_W = fids_pkg::PC_W
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [fids_pkg::INSTR_W-1:0] instr,
  output logic instr_ready,
  output logic discard,
  // program counter high latch from the core
  input wire logic [fids_pkg::LATCH_W-1:0] pc_high_latch,
  // file register read port
  output logic [FADDR_W-1:0] file_raddr,
  input wire logic [DATA_W-1:0] file_rdata,
  // file register write port
  output logic file_we,
  output logic [FADDR_W-1:0] file_waddr,
  output logic [DATA_W-1:0] file_wdata,
  // core state
  output logic [DATA_W-1:0] work_reg,
  output logic zero_flag,
  output logic [PC_W-1:0] pc
);

  //////////////////////////////////////////////////////////////////////////////

  typedef struct packed {
    fids_pkg::fids_mode_t mode;
    logic [DATA_W-1:0] work;
    logic zero;
    logic [PC_W-1:0] pc;
    logic we;
    logic [FADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
  } fids_state_t;

  fids_state_t st_reg;
  fids_state_t st_next;
  fids_pkg::fids_op_t op;
  logic [DATA_W-1:0] fdata;
  logic [DATA_W-1:0] result;
  logic res_zero;
  logic dest_file;
  logic exec_now;
  logic [fids_pkg::OPC_HI-fids_pkg::OPC_LO:0] opc;

  //////////////////////////////////////////////////////////////////////////////

  // decode; anything outside this subset runs as a plain one-cycle nop
  assign opc = instr[fids_pkg::OPC_HI:fids_pkg::OPC_LO];
  always_comb
  begin
    if (instr[fids_pkg::OPC_HI:fids_pkg::BR_OPC_LO] == fids_pkg::OPC_BRANCH)
      op = fids_pkg::OP_BRANCH;
    else if (opc == fids_pkg::OPC_DEC_SKIP)
      op = fids_pkg::OP_DEC_SKIP;
    else if (opc == fids_pkg::OPC_INC_SKIP)
      op = fids_pkg::OP_INC_SKIP;
    else if (opc == fids_pkg::OPC_INC)
      op = fids_pkg::OP_INC;
    else if (opc == fids_pkg::OPC_OR_FILE)
      op = fids_pkg::OP_OR_FILE;
    else if (opc == fids_pkg::OPC_OR_LIT)
      op = fids_pkg::OP_OR_LIT;
    else
      op = fids_pkg::OP_NONE;
  end

  assign dest_file = instr[fids_pkg::DEST_BIT];
  assign file_raddr = instr[FADDR_W-1:0];
  assign exec_now = ce && instr_valid && (st_reg.mode == fids_pkg::MODE_EXEC);

  // the write lands one cycle late, so a back-to-back read of the same file is
  // forwarded here instead of stalling the stream
  assign fdata = (st_reg.we && st_reg.waddr == file_raddr) ? st_reg.wdata : file_rdata;

  fids_alu #(
    .DATA_W(DATA_W)
  ) u_alu (
    .op(op),
    .work(st_reg.work),
    .file(fdata),
    .lit(instr[DATA_W-1:0]),
    .result(result),
    .res_zero(res_zero)
  );

  //////////////////////////////////////////////////////////////////////////////

  // next state: one word consumed per enabled cycle with a valid word
  always_comb
  begin
    st_next = st_reg;
    st_next.we = 1'b0;
    if (instr_valid && st_reg.mode == fids_pkg::MODE_FLUSH)
    begin
      st_next.pc = PC_W'(st_reg.pc + fids_pkg::PC_STEP);
      st_next.mode = fids_pkg::MODE_EXEC;
    end
    else if (instr_valid)
    begin
      st_next.pc = PC_W'(st_reg.pc + fids_pkg::PC_STEP);
      unique case (op)
        fids_pkg::OP_DEC_SKIP, fids_pkg::OP_INC_SKIP, fids_pkg::OP_INC, fids_pkg::OP_OR_FILE:
        begin
          if (dest_file)
          begin
            st_next.we = 1'b1;
            st_next.waddr = file_raddr;
            st_next.wdata = result;
          end
          else
          begin
            st_next.work = result;
          end
          // skip forms leave the zero flag alone
          if (op == fids_pkg::OP_INC || op == fids_pkg::OP_OR_FILE)
            st_next.zero = res_zero;
          // untaken skip stays in exec mode
          if (op != fids_pkg::OP_INC && op != fids_pkg::OP_OR_FILE && res_zero)
            st_next.mode = fids_pkg::MODE_FLUSH;
        end
        fids_pkg::OP_OR_LIT:
        begin
          st_next.work = result;
          st_next.zero = res_zero;
        end
        fids_pkg::OP_BRANCH:
        begin
          st_next.pc = {pc_high_latch[fids_pkg::LATCH_HI:fids_pkg::LATCH_LO],
                        instr[fids_pkg::BR_W-1:0]};
          st_next.mode = fids_pkg::MODE_FLUSH;
        end
        fids_pkg::OP_NONE:
        begin
          st_next.mode = fids_pkg::MODE_EXEC;
        end
      endcase
    end
  end

  // state register; ce low freezes everything including the pending write
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      st_reg.mode <= fids_pkg::MODE_EXEC;
      st_reg.work <= fids_pkg::W_RST;
      st_reg.zero <= 1'b0;
      st_reg.pc <= fids_pkg::PC_RST;
      st_reg.we <= 1'b0;
      st_reg.waddr <= '0;
      st_reg.wdata <= fids_pkg::W_RST;
    end
    else if (ce)
    begin
      st_reg <= st_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  // outputs
  assign instr_ready = ce;
  assign discard = ce && instr_valid && (st_reg.mode == fids_pkg::MODE_FLUSH);
  assign file_we = st_reg.we && ce; // a frozen cycle must not write twice
  assign file_waddr = st_reg.waddr;
  assign file_wdata = st_reg.wdata;
  assign work_reg = st_reg.work;
  assign zero_flag = st_reg.zero;
  assign pc = st_reg.pc;

  //////////////////////////////////////////////////////////////////////////////

  // checks on the executed result and its timing
  a_dec_result: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_DEC_SKIP && dest_file
    |=> st_reg.we && st_reg.wdata == DATA_W'($past(fdata) - fids_pkg::ONE))
    else $error("decrement result not written to file");

  a_dec_skip_zero: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_DEC_SKIP && fdata == fids_pkg::ONE
    ##1 (ce && instr_valid) |-> discard)
    else $error("zero decrement did not discard next word");

  a_skip_keeps_flag: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && (op == fids_pkg::OP_INC_SKIP || op == fids_pkg::OP_DEC_SKIP)
    |=> zero_flag == $past(zero_flag))
    else $error("skip instruction changed zero flag");

  a_inc_skip_work: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_INC_SKIP && !dest_file
    |=> work_reg == DATA_W'($past(fdata) + fids_pkg::ONE) && !st_reg.we)
    else $error("increment-skip result not in work");

  a_inc_skip_zero: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_INC_SKIP && fdata == fids_pkg::ALL_ONES
    |=> st_reg.mode == fids_pkg::MODE_FLUSH)
    else $error("zero increment-skip did not skip");

  a_branch_target: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_BRANCH
    |=> pc == {$past(pc_high_latch[fids_pkg::LATCH_HI:fids_pkg::LATCH_LO]),
               $past(instr[fids_pkg::BR_W-1:0])})
    else $error("branch target wrong");

  a_branch_two_cycles: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_BRANCH ##1 (ce && instr_valid)
    |-> discard ##1 (st_reg.mode == fids_pkg::MODE_EXEC))
    else $error("branch not two cycles");

  a_or_literal: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_OR_LIT
    |=> work_reg == ($past(st_reg.work) | $past(instr[DATA_W-1:0]))
        && zero_flag == (work_reg == fids_pkg::ZERO))
    else $error("or with literal wrong");

  a_inc_zero_flag: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_INC
    |=> zero_flag == ($past(fdata) == fids_pkg::ALL_ONES))
    else $error("increment zero flag wrong");

  a_or_file_dest: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && op == fids_pkg::OP_OR_FILE && dest_file
    |=> st_reg.we && st_reg.wdata == ($past(st_reg.work) | $past(fdata))
        && work_reg == $past(st_reg.work))
    else $error("or with file wrong");

  a_single_cycle: assert property (@(posedge sys_clk) disable iff (rst)
    exec_now && (op == fids_pkg::OP_INC || op == fids_pkg::OP_OR_FILE
                 || op == fids_pkg::OP_OR_LIT)
    |=> st_reg.mode == fids_pkg::MODE_EXEC)
    else $error("single-cycle instruction stretched");

endmodule

// >>> verification/tb.sv
// self-checking testbench for the file/branch execution unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin n_checks++; if ((gt) !== (ex)) begin err_count++; \
  $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb;
  typedef struct {
    logic [7:0] w;
    logic z;
    logic [14:0] pc;
    logic we;
    logic [6:0] wa;
    logic [7:0] wd;
    logic disc;
  } fids_note_t;
  ////////////////////////////////////////////////////////////////////////////////
  // design signals
  logic sys_clk, rst, ce, instr_valid, instr_ready, discard, file_we, zero_flag;
  logic [13:0] instr;
  logic [6:0] pc_high_latch, file_raddr, file_waddr;
  logic [7:0] file_rdata, file_wdata, work_reg;
  logic [14:0] pc;
  // bench state: design-facing memory, model memory and model registers
  logic [7:0] mem [128];
  logic [7:0] fm [128];
  logic [7:0] m_w;
  logic m_z, m_fl;
  logic [14:0] m_pc;
  logic [31:0] rv;
  int seed = 75;
  int err_count = 0;
  int n_checks = 0;
  fids_note_t q[$];
  fids_exec i_dut (.sys_clk(sys_clk), .rst(rst), .ce(ce), .instr_valid(instr_valid),
    .instr(instr), .instr_ready(instr_ready), .discard(discard),
    .pc_high_latch(pc_high_latch), .file_raddr(file_raddr), .file_rdata(file_rdata),
    .file_we(file_we), .file_waddr(file_waddr), .file_wdata(file_wdata),
    .work_reg(work_reg), .zero_flag(zero_flag), .pc(pc));
  ////////////////////////////////////////////////////////////////////////////////
  // file memory: combinational read, write on the strobe edge
  assign file_rdata = mem[file_raddr];
  always @(posedge sys_clk)
  begin
    if (file_we === 1'b1)
      mem[file_waddr] <= file_wdata;
  end
  // clock
  initial
  begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic close_out();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // offer one word and note what the model expects one cycle after it is taken
  task automatic issue(input logic [13:0] w, input logic [6:0] lat);
    fids_note_t n;
    logic [7:0] r;
    logic [5:0] op;
    logic [6:0] f;
    op = w[13:8];
    f = w[6:0];
    n.we = 1'b0;
    n.wa = 7'h00;
    n.wd = 8'h00;
    n.disc = m_fl;
    r = m_w;
    @(posedge sys_clk);
    ce <= 1'b1;
    instr_valid <= 1'b1;
    instr <= w;
    pc_high_latch <= lat;
    if (m_fl)
    begin
      m_fl = 1'b0;
      m_pc = m_pc + 15'h0001;
    end
    else if (w[13:11] == 3'h5)
    begin
      m_pc = {lat[6:3], w[10:0]};
      m_fl = 1'b1;
    end
    else
    begin
      m_pc = m_pc + 15'h0001;
      if (op == fids_pkg::OPC_DEC_SKIP)
        r = fm[f] - 8'h01;
      else if (op == fids_pkg::OPC_INC_SKIP || op == fids_pkg::OPC_INC)
        r = fm[f] + 8'h01;
      else if (op == fids_pkg::OPC_OR_FILE)
        r = m_w | fm[f];
      else if (op == fids_pkg::OPC_OR_LIT)
        r = m_w | w[7:0];
      if (op == fids_pkg::OPC_DEC_SKIP || op == fids_pkg::OPC_INC_SKIP ||
          op == fids_pkg::OPC_INC || op == fids_pkg::OPC_OR_FILE)
      begin
        if (w[7])
        begin
          fm[f] = r;
          n.we = 1'b1;
          n.wa = f;
          n.wd = r;
        end
        else
          m_w = r;
        if (op == fids_pkg::OPC_DEC_SKIP || op == fids_pkg::OPC_INC_SKIP)
          m_fl = (r == 8'h00);
        else
          m_z = (r == 8'h00);
      end
      else if (op == fids_pkg::OPC_OR_LIT)
      begin
        m_w = r;
        m_z = (r == 8'h00);
      end
    end
    n.w = m_w;
    n.z = m_z;
    n.pc = m_pc;
    q.push_back(n);
  endtask
  // gap with junk on the word lines
  task automatic idle(input int k);
    repeat (k)
    begin
      @(posedge sys_clk);
      rv = $random(seed);
      ce <= 1'b1;
      instr_valid <= 1'b0;
      instr <= rv[13:0];
    end
  endtask
  // frozen cycles: a word is offered but must not be taken
  task automatic freeze(input int k);
    idle(1);
    repeat (k)
    begin
      @(posedge sys_clk);
      rv = $random(seed);
      ce <= 1'b0;
      instr_valid <= 1'b1;
      instr <= rv[13:0];
      #1 `CHK("instr_ready", 1'b0, instr_ready)
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each taken word yields one result a cycle later
  initial
  begin
    fids_note_t n;
    logic d;
    forever
    begin
      @(posedge sys_clk);
      if (ce === 1'b1 && instr_valid === 1'b1 && rst === 1'b0)
      begin
        d = discard;
        `CHK("instr_ready", 1'b1, instr_ready)
        `CHK("file_raddr", instr[6:0], file_raddr)
        #1;
        n = q.pop_front();
        `CHK("discard", n.disc, d)
        `CHK("work_reg", n.w, work_reg)
        `CHK("zero_flag", n.z, zero_flag)
        `CHK("pc", n.pc, pc)
        `CHK("file_we", n.we, file_we)
        if (n.we)
        begin
          `CHK("file_waddr", n.wa, file_waddr)
          `CHK("file_wdata", n.wd, file_wdata)
        end
      end
    end
  end
  // watchdog: the whole sequence needs well under a thousand cycles
  initial
  begin
    #20000;
    err_count++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    rst = 1'b1;
    ce = 1'b0;
    instr_valid = 1'b0;
    instr = 14'h0000;
    pc_high_latch = 7'h00;
    m_w = 8'h00;
    m_z = 1'b0;
    m_fl = 1'b0;
    m_pc = 15'h0000;
    for (int i = 0; i < 128; i++)
    begin
      rv = $random(seed);
      mem[i] = rv[7:0];
      fm[i] = rv[7:0];
    end
    mem[5] = 8'hff;
    fm[5] = 8'hff;
    mem[6] = 8'h01;
    fm[6] = 8'h01;
    mem[7] = 8'h00;
    fm[7] = 8'h00;
    mem[8] = 8'hff;
    fm[8] = 8'hff;
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    #1 `CHK("pc", 15'h0000, pc)
    `CHK("work_reg", 8'h00, work_reg)
    // zero literal sets zero, then nonzero clears it
    issue({fids_pkg::OPC_OR_LIT, 8'h00}, 7'h00);
    issue({fids_pkg::OPC_OR_LIT, 8'h5a}, 7'h00);
    // skip to zero with the next word discarded, then an untaken skip back to back
    issue({fids_pkg::OPC_INC_SKIP, 1'b1, 7'h05}, 7'h00);
    idle(2); // the pending discard must wait out the gap
    issue({fids_pkg::OPC_OR_LIT, 8'hff}, 7'h00);
    issue({fids_pkg::OPC_INC_SKIP, 1'b0, 7'h05}, 7'h00);
    issue({fids_pkg::OPC_DEC_SKIP, 1'b1, 7'h06}, 7'h00);
    issue({fids_pkg::OPC_INC, 1'b1, 7'h07}, 7'h00);
    issue({fids_pkg::OPC_DEC_SKIP, 1'b0, 7'h06}, 7'h00);
    // increment to zero and or-file both ways
    issue({fids_pkg::OPC_INC, 1'b1, 7'h08}, 7'h00);
    issue({fids_pkg::OPC_INC, 1'b0, 7'h08}, 7'h00);
    issue({fids_pkg::OPC_OR_FILE, 1'b0, 7'h10}, 7'h00);
    issue({fids_pkg::OPC_OR_FILE, 1'b1, 7'h7f}, 7'h00);
    // branches, one discarding another, and an unsupported code
    issue({3'h5, 11'h7ff}, 7'h78);
    issue({3'h5, 11'h000}, 7'h07);
    issue({6'h01, 8'h00}, 7'h00);
    issue({3'h5, 11'h2a5}, 7'h4b);
    freeze(3);
    issue({fids_pkg::OPC_OR_LIT, 8'h00}, 7'h00);
    // random mix with close address reuse and gaps
    repeat (60)
    begin
      rv = $random(seed);
      case (rv[2:0])
        3'h0: issue({fids_pkg::OPC_DEC_SKIP, rv[8], 3'h0, rv[12:9]}, rv[22:16]);
        3'h1: issue({fids_pkg::OPC_INC_SKIP, rv[8], 3'h0, rv[12:9]}, rv[22:16]);
        3'h2: issue({fids_pkg::OPC_INC, rv[8], 3'h0, rv[12:9]}, rv[22:16]);
        3'h3: issue({fids_pkg::OPC_OR_FILE, rv[8], 3'h0, rv[12:9]}, rv[22:16]);
        3'h4: issue({fids_pkg::OPC_OR_LIT, rv[15:8]}, rv[22:16]);
        default: issue({3'h5, rv[26:16]}, rv[14:8]);
      endcase
      if (rv[31])
        idle(1);
    end
    idle(3);
    `CHK("note_queue", 0, q.size())
    close_out();
  end
endmodule
